// File: rtl/mode_cfg_pkg.sv
/*
  Shared constants, field layout and carrier types for the hidden mode
  configuration registers. Assumes a single 100 MHz clock domain.
*/
package mode_cfg_pkg;
  // page-0 register offsets of the two hidden registers
  localparam logic [3:0] OFS_MODE_A = 4'hA;
  localparam logic [3:0] OFS_MODE_B = 4'hB;
  // software-address sequence
  localparam logic [9:0] SOFT_ADDR_PORT = 10'h278;
  localparam int SOFT_WRITES = 4;
  localparam logic [2:0] BASE_SOFT = 3'h1;
  localparam logic [9:0] WINDOW_BYTES = 10'h20;
  // mode_config_a field positions
  localparam int A_BASE_LSB = 0;
  localparam int A_IRQ_LSB = 3;
  localparam int A_FAST_BIT = 6;
  localparam int A_RSV_BIT = 7;
  // mode_config_b field positions
  localparam int B_LINK_BIT = 2;
  localparam int B_BERR_BIT = 5;
  // reset values
  localparam logic [7:0] MODE_A_RESET = 8'h00;
  localparam logic [7:0] MODE_B_RESET = 8'h00;
  // base code to I/O base, index = code; code 001 has no window
  localparam logic [9:0] BASE_MAP [8] = '{10'h300, 10'h000, 10'h240, 10'h280,
                                         10'h2C0, 10'h320, 10'h340, 10'h360};
  // irq code to interrupt line number
  localparam logic [3:0] IRQ_MAP [8] = '{4'h3, 4'h4, 4'h5, 4'h9,
                                        4'hA, 4'hB, 4'hC, 4'hF};

  typedef struct packed {
    logic access;
    logic write;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic write;
    logic [9:0] addr;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic rsv;
    logic fast;
    logic [2:0] irq;
    logic [2:0] base;
  } mode_a_s;

  typedef enum logic [1:0] {
    ARM_NONE = 2'b00,
    ARM_A = 2'b01,
    ARM_B = 2'b10
  } arm_e;
endpackage : mode_cfg_pkg

// File: rtl/io_base_decoder.sv
/*
  Maps the base-address code to the I/O window and flags hits in it.
  Assumes the I/O address is already synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module io_base_decoder
(
  // clocking, only for the checks
  input wire logic mclk,
  input wire logic rst,
  // configuration
  input wire logic [2:0] base_code,
  input wire logic [9:0] io_addr,
  // decode results
  output logic [9:0] io_base,
  output logic io_decode_en,
  output logic io_hit
);
  logic [9:0] offset;

  always_comb
  begin
    io_base = mode_cfg_pkg::BASE_MAP[base_code];
    io_decode_en = (base_code != mode_cfg_pkg::BASE_SOFT);
    offset = io_addr - io_base;
    io_hit = io_decode_en && (offset < mode_cfg_pkg::WINDOW_BYTES);
  end

  a_soft_code_quiet: assert property (@(posedge mclk) disable iff (rst)
    (base_code == mode_cfg_pkg::BASE_SOFT) |-> (!io_decode_en && !io_hit))
    else $error("decoder answers while in software-address mode");

  a_base_0240: assert property (@(posedge mclk) disable iff (rst)
    (base_code == 3'h2) |-> (io_base == 10'h240))
    else $error("code 010 does not give base 0240");
endmodule : io_base_decoder
`default_nettype wire

// File: rtl/soft_addr_loader.sv
/*
  Watches I/O writes for the run of consecutive writes to the
  software-address port and yields one load pulse per power-on reset.
  Assumes rst is the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module soft_addr_loader #(
  parameter int WRITES_NEEDED = mode_cfg_pkg::SOFT_WRITES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // I/O side
  input wire mode_cfg_pkg::io_req_s io_req,
  input wire logic soft_mode,
  // load to mode_config_a
  output logic load,
  output logic [2:0] load_value
);
  generate
    if (WRITES_NEEDED < 1 || WRITES_NEEDED > 7)
    begin : g_bad
      $error("WRITES_NEEDED must be 1 to 7");
    end
  endgenerate

  logic [2:0] count;
  logic [2:0] next_count;
  logic done;
  logic next_done;
  logic hit;

  always_comb
  begin
    next_count = count;
    next_done = done;
    hit = io_req.write && (io_req.addr == mode_cfg_pkg::SOFT_ADDR_PORT);
    load = 1'b0;
    load_value = io_req.wdata[2:0];
    if (io_req.write && soft_mode && !done)
    begin
      // any other write breaks the run
      next_count = hit ? count + 3'h1 : 3'h0;
      if (hit && (count == 3'(WRITES_NEEDED - 1)))
      begin
        load = 1'b1;
        next_done = 1'b1;
        next_count = 3'h0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count <= 3'h0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= next_done;
    end
  end

  a_soft_once: assert property (@(posedge mclk) disable iff (rst)
    done |-> !load)
    else $error("software address loaded twice");

  a_soft_run: assert property (@(posedge mclk) disable iff (rst)
    load |-> (hit && soft_mode && count == 3'(WRITES_NEEDED - 1)))
    else $error("load without consecutive port writes");

  // idle cycles may sit between port writes, so only foreign writes reset the run
  a_soft_break: assert property (@(posedge mclk) disable iff (rst)
    (io_req.write && !hit && soft_mode && !done) |=> (count == 3'h0))
    else $error("foreign write did not break the port run");
endmodule : soft_addr_loader
`default_nettype wire

// File: rtl/hidden_mode_config_registers.sv
/*
  Hidden mode configuration registers A and B behind page-0 offsets
  0AH/0BH, with remote byte count redirection, software base-address
  load and the bus-error / link bits of register B.
  Assumes one page-0 register access strobe per cycle at most, and that
  I/O writes and events are synchronous to mclk.
*/
// Summary of operation
// - read 0AH returns A; armed write loads A
// - intervening access redirects 0AH write to count 0
// - read 0BH returns B; armed write loads B
// - intervening access redirects 0BH write to count 1
// - A bits 2:0 select 20H-byte base
// - code 001 answers no I/O address
// - four writes to 278H load base bits
// - software load works once per power-on reset
// - A bits 5:3 select interrupt line
// - A bit 6 enables early port fetch
// - writing one clears B bus error flag
// - B bit 2 disables link test; reads status
`timescale 1ns/1ps
`default_nettype none
module hidden_mode_config_registers
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // page-0 register access
  input wire mode_cfg_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // redirected remote byte count writes
  output logic rbc_wr,
  output logic rbc_sel,
  output logic [7:0] rbc_data,
  // ISA I/O writes for the software-address port
  input wire mode_cfg_pkg::io_req_s io_req,
  output logic io_hit,
  // status from the rest of the controller
  input wire logic bus_error_event,
  input wire logic link_status,
  // configuration outputs
  output logic [9:0] io_base,
  output logic io_decode_en,
  output logic [3:0] irq_number,
  output logic fast_port_fetch,
  output logic link_test_disable,
  output logic bus_error_flag,
  output logic [7:0] mode_b_plain
);
  mode_cfg_pkg::arm_e arm;
  mode_cfg_pkg::arm_e next_arm;
  mode_cfg_pkg::mode_a_s mode_config_a;
  mode_cfg_pkg::mode_a_s next_mode_a;
  logic [7:0] next_mode_b;
  logic next_link_dis;
  logic next_berr;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_rbc_wr;
  logic next_rbc_sel;
  logic [7:0] next_rbc_data;
  logic soft_load;
  logic [2:0] soft_value;
  logic rd_a;
  logic rd_b;
  logic wr_a;
  logic wr_b;
  logic berr_clear;

  soft_addr_loader #(
    .WRITES_NEEDED(mode_cfg_pkg::SOFT_WRITES)
  ) u_loader (
    .mclk(mclk),
    .rst(rst),
    .io_req(io_req),
    .soft_mode(mode_config_a.base == mode_cfg_pkg::BASE_SOFT),
    .load(soft_load),
    .load_value(soft_value)
  );

  io_base_decoder u_decoder (
    .mclk(mclk),
    .rst(rst),
    .base_code(mode_config_a.base),
    .io_addr(io_req.addr),
    .io_base(io_base),
    .io_decode_en(io_decode_en),
    .io_hit(io_hit)
  );

  // field views of register A
  always_comb
  begin
    irq_number = mode_cfg_pkg::IRQ_MAP[mode_config_a.irq];
    fast_port_fetch = mode_config_a.fast;
  end

  always_comb
  begin
    rd_a = reg_req.access && !reg_req.write && (reg_req.addr == mode_cfg_pkg::OFS_MODE_A);
    rd_b = reg_req.access && !reg_req.write && (reg_req.addr == mode_cfg_pkg::OFS_MODE_B);
    wr_a = reg_req.access && reg_req.write && (reg_req.addr == mode_cfg_pkg::OFS_MODE_A);
    wr_b = reg_req.access && reg_req.write && (reg_req.addr == mode_cfg_pkg::OFS_MODE_B);
    next_arm = arm;
    next_mode_a = mode_config_a;
    next_mode_b = mode_b_plain;
    next_link_dis = link_test_disable;
    next_rbc_wr = 1'b0;
    next_rbc_sel = rbc_sel;
    next_rbc_data = rbc_data;
    next_rvalid = rd_a || rd_b;
    next_rdata = reg_rdata;
    berr_clear = 1'b0;
    // only a read of 0AH/0BH arms; every other access disarms
    if (reg_req.access)
    begin
      case (1'b1)
        rd_a: next_arm = mode_cfg_pkg::ARM_A;
        rd_b: next_arm = mode_cfg_pkg::ARM_B;
        default: next_arm = mode_cfg_pkg::ARM_NONE;
      endcase
    end
    if (rd_a)
    begin
      next_rdata = mode_config_a;
    end
    if (rd_b)
    begin
      next_rdata = mode_b_plain;
      next_rdata[mode_cfg_pkg::B_LINK_BIT] = link_status;
      next_rdata[mode_cfg_pkg::B_BERR_BIT] = bus_error_flag;
    end
    if (wr_a)
    begin
      if (arm == mode_cfg_pkg::ARM_A)
      begin
        // bit 7 stored as written; keeping it low is software's duty
        next_mode_a = reg_req.wdata;
      end
      else
      begin
        next_rbc_wr = 1'b1;
        next_rbc_sel = 1'b0;
        next_rbc_data = reg_req.wdata;
      end
    end
    if (wr_b)
    begin
      if (arm == mode_cfg_pkg::ARM_B)
      begin
        // full value taken; bits 2 and 5 are not plain storage
        next_mode_b = reg_req.wdata;
        next_mode_b[mode_cfg_pkg::B_LINK_BIT] = 1'b0;
        next_mode_b[mode_cfg_pkg::B_BERR_BIT] = 1'b0;
        next_link_dis = reg_req.wdata[mode_cfg_pkg::B_LINK_BIT];
        berr_clear = reg_req.wdata[mode_cfg_pkg::B_BERR_BIT];
      end
      else
      begin
        next_rbc_wr = 1'b1;
        next_rbc_sel = 1'b1;
        next_rbc_data = reg_req.wdata;
      end
    end
    if (soft_load)
    begin
      next_mode_a.base = soft_value;
    end
    // a new bus error in the clearing cycle is kept
    next_berr = (bus_error_flag && !berr_clear) || bus_error_event;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      arm <= mode_cfg_pkg::ARM_NONE;
      mode_config_a <= mode_cfg_pkg::MODE_A_RESET;
      mode_b_plain <= mode_cfg_pkg::MODE_B_RESET;
      link_test_disable <= 1'b0;
      bus_error_flag <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      rbc_wr <= 1'b0;
      rbc_sel <= 1'b0;
      rbc_data <= 8'h00;
    end
    else
    begin
      arm <= next_arm;
      mode_config_a <= next_mode_a;
      mode_b_plain <= next_mode_b;
      link_test_disable <= next_link_dis;
      bus_error_flag <= next_berr;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      rbc_wr <= next_rbc_wr;
      rbc_sel <= next_rbc_sel;
      rbc_data <= next_rbc_data;
    end
  end

  a_read_arms_a: assert property (@(posedge mclk) disable iff (rst)
    rd_a |=> (arm == mode_cfg_pkg::ARM_A && reg_rvalid && reg_rdata == $past(mode_config_a)))
    else $error("read of 0AH did not arm or return A");

  a_hidden_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_a && arm == mode_cfg_pkg::ARM_A && !soft_load)
    |=> (mode_config_a == $past(reg_req.wdata) && !rbc_wr))
    else $error("armed write did not land in A");

  a_stray_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_a && arm != mode_cfg_pkg::ARM_A && !soft_load)
    |=> (rbc_wr && !rbc_sel && $stable(mode_config_a)))
    else $error("unarmed 0AH write missed count 0");

  a_intervene_disarm: assert property (@(posedge mclk) disable iff (rst)
    (reg_req.access && !rd_a && !rd_b) |=> (arm == mode_cfg_pkg::ARM_NONE))
    else $error("other access left a register armed");

  a_hidden_write_b: assert property (@(posedge mclk) disable iff (rst)
    (wr_b && arm == mode_cfg_pkg::ARM_B)
    |=> (!rbc_wr && link_test_disable == $past(reg_req.wdata[2])))
    else $error("armed write did not land in B");

  a_stray_write_b: assert property (@(posedge mclk) disable iff (rst)
    (wr_b && arm != mode_cfg_pkg::ARM_B) |=> (rbc_wr && rbc_sel && $stable(mode_b_plain)))
    else $error("unarmed 0BH write missed count 1");

  a_soft_load_a: assert property (@(posedge mclk) disable iff (rst)
    soft_load |=> (mode_config_a.base == $past(soft_value)))
    else $error("software load did not reach base bits");

  a_berr_clear: assert property (@(posedge mclk) disable iff (rst)
    (berr_clear && !bus_error_event) |=> !bus_error_flag)
    else $error("writing one did not clear bus error");

  a_berr_keep: assert property (@(posedge mclk) disable iff (rst)
    (bus_error_flag && !berr_clear) |=> bus_error_flag)
    else $error("bus error lost without a clearing write");

  a_link_read: assert property (@(posedge mclk) disable iff (rst)
    rd_b |=> (reg_rdata[2] == $past(link_status)))
    else $error("read of B bit 2 is not link status");

  a_irq_map: assert property (@(posedge mclk) disable iff (rst)
    (mode_config_a.irq == 3'h3) |-> (irq_number == 4'h9))
    else $error("irq code 011 does not give line 9");

  a_berr_set_wins: assert property (@(posedge mclk) disable iff (rst)
    (berr_clear && bus_error_event) |=> bus_error_flag)
    else $error("clearing write beat a new bus error");

  a_read_arms_b: assert property (@(posedge mclk) disable iff (rst)
    rd_b |=> (arm == mode_cfg_pkg::ARM_B && reg_rvalid))
    else $error("read of 0BH did not arm or answer");

  a_rvalid_reads: assert property (@(posedge mclk) disable iff (rst)
    !(rd_a || rd_b) |=> !reg_rvalid)
    else $error("read valid without a hidden read");

  a_read_b_flag: assert property (@(posedge mclk) disable iff (rst)
    rd_b |=> (reg_rdata[5] == $past(bus_error_flag)))
    else $error("read of B bit 5 is not the bus error flag");

  a_link_dis_hold: assert property (@(posedge mclk) disable iff (rst)
    !(wr_b && arm == mode_cfg_pkg::ARM_B) |=> $stable(link_test_disable))
    else $error("link test control changed without armed write");

  a_mode_a_hold: assert property (@(posedge mclk) disable iff (rst)
    (!(wr_a && arm == mode_cfg_pkg::ARM_A) && !soft_load) |=> $stable(mode_config_a))
    else $error("register A changed without armed write");

  a_mode_b_hold: assert property (@(posedge mclk) disable iff (rst)
    !(wr_b && arm == mode_cfg_pkg::ARM_B) |=> $stable(mode_b_plain))
    else $error("register B changed without armed write");

  a_rbc_quiet: assert property (@(posedge mclk) disable iff (rst)
    !(wr_a || wr_b) |=> !rbc_wr)
    else $error("count write without a 0AH or 0BH write");

  a_rbc_data_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_a && arm != mode_cfg_pkg::ARM_A) |=> (rbc_data == $past(reg_req.wdata)))
    else $error("redirected 0AH data wrong");

  a_rbc_data_b: assert property (@(posedge mclk) disable iff (rst)
    (wr_b && arm != mode_cfg_pkg::ARM_B) |=> (rbc_data == $past(reg_req.wdata)))
    else $error("redirected 0BH data wrong");

  a_idle_keeps_arm: assert property (@(posedge mclk) disable iff (rst)
    !reg_req.access |=> $stable(arm))
    else $error("idle cycle changed the arm state");

  a_irq_top_line: assert property (@(posedge mclk) disable iff (rst)
    (mode_config_a.irq == 3'h7) |-> (irq_number == 4'hF))
    else $error("irq code 111 does not give line 15");

  a_soft_in_mode: assert property (@(posedge mclk) disable iff (rst)
    soft_load |-> (mode_config_a.base == mode_cfg_pkg::BASE_SOFT))
    else $error("software load outside software-address mode");
endmodule : hidden_mode_config_registers
`default_nettype wire

// File: tb/isa_host_model.sv
/*
  Host model: drives page-0 register accesses and ISA I/O writes.
  Assumes the block samples both request buses on rising mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_host_model
(
  // clock
  input wire logic mclk,
  // requests
  output var mode_cfg_pkg::reg_req_s reg_req,
  output var mode_cfg_pkg::io_req_s io_req,
  // answers
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic rbc_wr,
  input wire logic io_hit
);
  initial
  begin
    reg_req = '0;
    io_req = '0;
  end

  // released fields carry inverted values so stale data never looks valid
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] rd, output logic rv, output logic rw);
    @(posedge mclk);
    reg_req <= '{1'b1, w, a, d};
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    rd = reg_rdata;
    rv = reg_rvalid;
    rw = rbc_wr;
  endtask : acc

  task automatic io_wr(input logic [9:0] a, input logic [7:0] d, output logic hit);
    @(posedge mclk);
    io_req <= '{1'b1, a, d};
    #1;
    hit = io_hit;
    @(posedge mclk);
    io_req <= '{1'b0, ~a, ~d};
    #1;
  endtask : io_wr

  // read then write of one offset, nothing in between
  task automatic cfg_write(input logic b, input logic [7:0] d);
    logic [7:0] rd;
    logic rv;
    logic rw;
    logic [3:0] a;
    a = b ? mode_cfg_pkg::OFS_MODE_B : mode_cfg_pkg::OFS_MODE_A;
    acc(1'b0, a, 8'h00, rd, rv, rw);
    // full value composed, reserved bit of A kept low
    acc(1'b1, a, b ? d : (d & 8'h7F), rd, rv, rw);
  endtask : cfg_write

  task automatic soft_seq(input logic [2:0] v);
    logic hit;
    repeat (mode_cfg_pkg::SOFT_WRITES) io_wr(mode_cfg_pkg::SOFT_ADDR_PORT, {5'h00, v}, hit);
    @(posedge mclk);
    #1;
  endtask : soft_seq
endmodule : isa_host_model
`default_nettype wire

// File: tb/hidden_mode_config_registers_tb.sv
/*
  Self-checking bench for the hidden mode configuration registers.
  Assumes the host model in isa_host_model drives both request buses.
*/
`timescale 1ns/1ps
`default_nettype none
module hidden_mode_config_registers_tb;
  localparam logic [3:0] RA = mode_cfg_pkg::OFS_MODE_A;
  localparam logic [3:0] RB = mode_cfg_pkg::OFS_MODE_B;
  localparam logic [9:0] SP = mode_cfg_pkg::SOFT_ADDR_PORT;
  localparam logic [9:0] BASE_TAB [8] = '{10'h300, 10'h000, 10'h240, 10'h280,
                                         10'h2C0, 10'h320, 10'h340, 10'h360};
  localparam logic [3:0] IRQ_TAB [8] = '{4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
  logic mclk;
  logic rst;
  mode_cfg_pkg::reg_req_s reg_req;
  mode_cfg_pkg::io_req_s io_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic rbc_wr;
  logic rbc_sel;
  logic [7:0] rbc_data;
  logic io_hit;
  logic bus_error_event;
  logic link_status;
  logic [9:0] io_base;
  logic io_decode_en;
  logic [3:0] irq_number;
  logic fast_port_fetch;
  logic link_test_disable;
  logic bus_error_flag;
  logic [7:0] mode_b_plain;
  logic [7:0] rd;
  logic rv;
  logic rw;
  logic hit;
  int fail_count = 0;
  int check_count = 0;

  hidden_mode_config_registers uut (.mclk(mclk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rbc_wr(rbc_wr), .rbc_sel(rbc_sel),
    .rbc_data(rbc_data), .io_req(io_req), .io_hit(io_hit),
    .bus_error_event(bus_error_event), .link_status(link_status), .io_base(io_base),
    .io_decode_en(io_decode_en), .irq_number(irq_number),
    .fast_port_fetch(fast_port_fetch), .link_test_disable(link_test_disable),
    .bus_error_flag(bus_error_flag), .mode_b_plain(mode_b_plain));

  isa_host_model host (.mclk(mclk), .reg_req(reg_req), .io_req(io_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rbc_wr(rbc_wr), .io_hit(io_hit));

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic t_reset;
    host.acc(1'b0, RA, 8'h00, rd, rv, rw);
    chk("rvalid", rv, 1'b1);
    chk("a reset", rd, 8'h00);
    chk("base reset", io_base, 10'h300);
    chk("irq reset", irq_number, 4'h3);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields;
    logic [2:0] c;
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      v = {1'b0, c[0], c, c};
      host.cfg_write(1'b0, v);
      host.acc(1'b0, RA, 8'h00, rd, rv, rw);
      chk("a readback", rd, v);
      chk("irq", irq_number, IRQ_TAB[i]);
      chk("fast", fast_port_fetch, c[0]);
      chk("decode en", io_decode_en, c != 3'h1);
      if (c != 3'h1)
        chk("base", io_base, BASE_TAB[i]);
    end
    $display("test fields done");
  endtask : t_fields

  task automatic t_redirect;
    host.cfg_write(1'b0, 8'h5A);
    // the first write consumed the arm
    host.acc(1'b1, RA, 8'h66, rd, rv, rw);
    chk("rbc wr", rw, 1'b1);
    chk("rbc sel", rbc_sel, 1'b0);
    chk("rbc data", rbc_data, 8'h66);
    host.acc(1'b0, RA, 8'h00, rd, rv, rw);
    host.acc(1'b0, RB, 8'h00, rd, rv, rw);
    host.acc(1'b1, RA, 8'h11, rd, rv, rw);
    chk("rbc data", rbc_data, 8'h11);
    host.acc(1'b0, RA, 8'h00, rd, rv, rw);
    chk("a kept", rd, 8'h5A);
    host.acc(1'b1, RB, 8'h77, rd, rv, rw);
    chk("rbc wr", rw, 1'b1);
    chk("rbc sel", rbc_sel, 1'b1);
    chk("rbc data", rbc_data, 8'h77);
    chk("b kept", mode_b_plain, 8'h00);
    $display("test redirect done");
  endtask : t_redirect

  task automatic t_reg_b;
    host.cfg_write(1'b1, 8'h04);
    chk("link dis", link_test_disable, 1'b1);
    @(posedge mclk);
    bus_error_event <= 1'b1;
    link_status <= 1'b1;
    @(posedge mclk);
    bus_error_event <= 1'b0;
    #1;
    chk("flag set", bus_error_flag, 1'b1);
    host.acc(1'b0, RB, 8'h00, rd, rv, rw);
    chk("b link", rd[2], 1'b1);
    chk("b flag", rd[5], 1'b1);
    host.acc(1'b1, RB, 8'hDB, rd, rv, rw);
    chk("flag kept", bus_error_flag, 1'b1);
    chk("b plain", mode_b_plain, 8'hDB);
    chk("link dis", link_test_disable, 1'b0);
    host.cfg_write(1'b1, 8'h20);
    chk("flag clr", bus_error_flag, 1'b0);
    // event held across the clearing write: the set must win
    @(posedge mclk);
    bus_error_event <= 1'b1;
    host.cfg_write(1'b1, 8'h20);
    chk("set wins", bus_error_flag, 1'b1);
    @(posedge mclk);
    bus_error_event <= 1'b0;
    $display("test reg b done");
  endtask : t_reg_b

  task automatic t_soft;
    host.cfg_write(1'b0, 8'h01);
    repeat (3) host.io_wr(SP, 8'h02, hit);
    // a foreign write breaks the run
    host.io_wr(10'h2F0, 8'h02, hit);
    host.io_wr(SP, 8'h02, hit);
    chk("hit off", hit, 1'b0);
    @(posedge mclk);
    #1;
    chk("no load", io_decode_en, 1'b0);
    // clear the partial run so the full sequence starts from zero
    host.io_wr(10'h2F0, 8'h02, hit);
    host.soft_seq(3'h3);
    chk("soft base", io_base, 10'h280);
    chk("irq kept", irq_number, 4'h3);
    host.io_wr(10'h29F, 8'h00, hit);
    chk("hit top", hit, 1'b1);
    host.io_wr(10'h2A0, 8'h00, hit);
    chk("hit past", hit, 1'b0);
    host.cfg_write(1'b0, 8'h01);
    host.soft_seq(3'h4);
    chk("once only", io_decode_en, 1'b0);
    $display("test soft done");
  endtask : t_soft

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    rst = 1'b1;
    bus_error_event = 1'b0;
    link_status = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_redirect();
    t_reg_b();
    t_soft();
    end_sim();
  end

  // whole run is well under a thousand cycles
  initial
  begin
    #50000;
    fail_count++;
    end_sim();
  end
endmodule : hidden_mode_config_registers_tb
`default_nettype wire
